/* hw/osc_otp_security.sv */
// OTP array, policy word, boot copy and debug chain of one tile.
// Assumes port writes come from tile software on clk, and the debug
// pins arrive from outside and are synchronised here.
`timescale 1ns/10ps
`include "osc_params.svh"
module osc_otp_security
  import osc_pkg::*;
#(
  // Identification values below are arbitrary
  parameter logic [3:0]  IdVersion  = 4'h0,
  parameter logic [15:0] IdPart     = 16'h0001,
  parameter logic [10:0] IdMaker    = 11'h001,
  parameter logic [17:0] SiliconRev = 18'h00001
)
(
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  // Programming ports, selected by resource number
  input  wire osc_req_t    portReq,
  output logic [31:0]      otpRdData,
  output logic [15:0]      otpStatus,
  // Boot copy towards SRAM
  output osc_sram_t        sramWr,
  output logic             bootDone,
  output logic             bootFromOtp,
  // Policy effects
  input  wire logic        linkReq,
  output logic             linkGrant,
  output logic             linkRefused,
  output logic             redundantRowsOn,
  output logic [6:0]       swSecField,
  // Debug pins
  input  wire logic        tck,
  input  wire logic        tms,
  input  wire logic        tdi,
  output logic             tdo,
  output logic             tdoEn_b
);

  // ----------------------------------------
  // Storage and policy
  // ----------------------------------------
  // Index OSC_WORDS holds the policy row, outside the four sectors
  logic [31:0] mem [0:`OSC_WORDS];
  logic [31:0] policy;
  osc_boot_t   bootState;
  logic [11:0] copyIdx;

  // OTP cells come up erased; they never see reset, being nonvolatile
  initial begin
    for (int i = 0; i <= `OSC_WORDS; i++) begin
      mem[i] = 32'h0;
    end
  end

  // ----------------------------------------
  // Port decode
  // ----------------------------------------
  logic [15:0] addrReg;
  logic [31:0] dataReg;
  wire  hitAddr = portReq.wr && (portReq.res == `OSC_RES_ADDR);
  wire  hitData = portReq.wr && (portReq.res == `OSC_RES_DATA);
  wire  hitCtrl = portReq.wr && (portReq.res == `OSC_RES_CTRL);
  wire  [1:0] cmd = portReq.data[1:0];
  wire  portProg = hitCtrl && (cmd == `OSC_CMD_PROG);
  wire  portRead = hitCtrl && (cmd == `OSC_CMD_READ);
  // Commands count only once bootDone shows, so software never sees a gap cycle
  wire  running  = (bootState == BOOT_RUN) && bootDone;

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      addrReg <= 16'h0;
      dataReg <= 32'h0;
    end else begin
      if (hitAddr) begin
        addrReg <= portReq.data[15:0];
      end
      if (hitData) begin
        dataReg <= portReq.data;
      end
    end
  end

  // ----------------------------------------
  // Debug pin synchroniser
  // ----------------------------------------
  // Order is {tdi, tms, tck}; a level counts once stages two and three agree
  logic [2:0] pinS1;
  logic [2:0] pinS2;
  logic [2:0] pinS3;
  logic [2:0] pinClean;
  logic       tckRise;
  logic       tckFall;
  wire  [2:0] agree      = ~(pinS2 ^ pinS3);
  wire  [2:0] next_clean = (agree & pinS3) | (~agree & pinClean);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      pinS1    <= 3'h2;
      pinS2    <= 3'h2;
      pinS3    <= 3'h2;
      pinClean <= 3'h2;
      tckRise  <= 1'b0;
      tckFall  <= 1'b0;
    end else begin
      pinS1    <= {tdi, tms, tck};
      pinS2    <= pinS1;
      pinS3    <= pinS2;
      pinClean <= next_clean;
      tckRise  <= next_clean[0] & ~pinClean[0];
      tckFall  <= ~next_clean[0] & pinClean[0];
    end
  end

  // ----------------------------------------
  // Debug chain: boundary TAP then chip TAP
  // ----------------------------------------
  logic [3:0]  bIr;
  logic [3:0]  cIr;
  osc_tapev_t  bEv;
  osc_tapev_t  cEv;
  logic        bSer;
  logic        cSer;
  logic        bBypass;
  logic [31:0] drSh;
  logic [15:0] dbgAddr;

  // Boundary cells sit outside this block, so its data path is bypass only
  osc_tap uBoundTap (
    .clk     (clk),
    .rst_b   (rst_b),
    .tckRise (tckRise),
    .tms     (pinClean[1]),
    .tdi     (pinClean[2]),
    .drOut   (bBypass),
    .ir      (bIr),
    .ev      (bEv),
    .serOut  (bSer)
  );

  osc_tap uChipTap (
    .clk     (clk),
    .rst_b   (rst_b),
    .tckRise (tckRise),
    .tms     (pinClean[1]),
    .tdi     (bSer),
    .drOut   (drSh[0]),
    .ir      (cIr),
    .ev      (cEv),
    .serOut  (cSer)
  );

  // Until the boot copy finishes and bootDone shows, the debug port is held shut
  wire jtagOff = !bootDone || policy[`OSC_PB_NOJTAG];
  wire otpOff  = jtagOff || policy[`OSC_PB_NOJOTP];
  wire isOtpIr = (cIr == `OSC_IR_OTPADDR) || (cIr == `OSC_IR_OTPDATA);
  wire [3:0] irEff = (jtagOff || (otpOff && isOtpIr)) ? `OSC_IR_BYPASS : cIr;

  wire [31:0] identWord = {IdVersion, IdPart, IdMaker, 1'b1};
  wire [31:0] userWord  = {policy[31:`OSC_PB_UID_LO], 4'h0, SiliconRev};
  wire [11:0] dbgIdx    = dbgAddr[11:0];
  wire        dbgValid  = (dbgAddr <= `OSC_POLICY_ADDR);
  wire [31:0] dbgWord   = dbgValid ? mem[dbgIdx] : 32'h0;
  wire        tdiC      = bSer;
  wire        dbgProg   = tckRise && cEv.updDr && (irEff == `OSC_IR_OTPDATA);

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bBypass <= 1'b0;
    end else if (tckRise && bEv.shDr) begin
      bBypass <= pinClean[2];
    end else if (tckRise && bEv.capDr) begin
      bBypass <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      drSh    <= 32'h0;
      dbgAddr <= 16'h0;
    end else if (tckRise && cEv.capDr) begin
      unique case (irEff)
        `OSC_IR_DEBUG_CHIP_IDENT:   drSh <= identWord;
        `OSC_IR_USERCODE: drSh <= userWord;
        `OSC_IR_OTPADDR:  drSh <= {16'h0, dbgAddr};
        `OSC_IR_OTPDATA:  drSh <= dbgWord;
        default:          drSh <= 32'h0;
      endcase
    end else if (tckRise && cEv.shDr) begin
      unique case (irEff)
        `OSC_IR_DEBUG_CHIP_IDENT, `OSC_IR_USERCODE, `OSC_IR_OTPDATA: drSh <= {tdiC, drSh[31:1]};
        `OSC_IR_OTPADDR:  drSh <= {16'h0, tdiC, drSh[15:1]};
        default:          drSh <= {31'h0, tdiC};
      endcase
    end else if (tckRise && cEv.updDr && (irEff == `OSC_IR_OTPADDR)) begin
      dbgAddr <= drSh[15:0];
    end
  end

  // Pin follows the chain on the falling clock, as a test port should
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      tdo     <= 1'b0;
      tdoEn_b <= 1'b1;
    end else if (tckFall) begin
      tdo     <= cSer;
      tdoEn_b <= !(bEv.shDr || bEv.shIr || cEv.shDr || cEv.shIr);
    end
  end

  // ----------------------------------------
  // Programming arbitration and locks
  // ----------------------------------------
  // Port wins a same-cycle clash; the debug write is then dropped and flagged
  wire        useDbg   = dbgProg && !portProg;
  wire [15:0] progAddr = useDbg ? dbgAddr : addrReg;
  wire [31:0] progData = useDbg ? drSh : dataReg;
  wire        progReq  = running && (portProg || dbgProg);
  wire        toPolicy = (progAddr == `OSC_POLICY_ADDR);
  wire        inArray  = (progAddr < `OSC_POLICY_ADDR);
  wire [1:0]  sector   = progAddr[10:9];
  wire        secLock  = policy[`OSC_PB_SLOCK + {30'h0, sector}];
  wire        allowed  = !policy[`OSC_PB_MLOCK]
                       && (toPolicy || (inArray && !secLock));
  wire        progDo   = progReq && allowed;
  wire        progNo   = (progReq && !allowed) || (dbgProg && portProg);
  wire [11:0] progIdx  = progAddr[11:0];

  // Fuses only ever blow, so programming ORs into the old word
  always_ff @(posedge clk) begin
    if (progDo) begin
      mem[progIdx] <= mem[progIdx] | progData;
    end
  end

  // ----------------------------------------
  // Power-up load and copy to SRAM
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      bootState <= BOOT_LOAD;
      policy    <= 32'h0;
      copyIdx   <= 12'h0;
      sramWr    <= '0;
      bootDone  <= 1'b0;
    end else begin
      unique case (bootState)
        BOOT_LOAD: begin
          policy    <= mem[`OSC_WORDS];
          bootState <= BOOT_COPY;
        end
        BOOT_COPY: begin
          sramWr.wr   <= 1'b1;
          sramWr.addr <= copyIdx[10:0];
          sramWr.data <= mem[copyIdx];
          copyIdx     <= copyIdx + 12'h1;
          if (copyIdx == 12'(`OSC_WORDS - 1)) begin
            bootState <= BOOT_RUN;
          end
        end
        BOOT_RUN: begin
          sramWr.wr <= 1'b0;
          bootDone  <= 1'b1;
        end
        default: begin
          bootState <= BOOT_LOAD;
        end
      endcase
    end
  end

  // ----------------------------------------
  // Policy effects and status
  // ----------------------------------------
  // Live policy never follows a programmed policy row until the next reset
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      linkGrant       <= 1'b0;
      linkRefused     <= 1'b0;
      bootFromOtp     <= 1'b0;
      redundantRowsOn <= 1'b0;
      swSecField      <= 7'h0;
      otpRdData       <= 32'h0;
      otpStatus       <= 16'h0;
    end else begin
      linkGrant       <= linkReq && bootDone && !policy[`OSC_PB_NOLINK];
      linkRefused     <= linkReq && !(bootDone && !policy[`OSC_PB_NOLINK]);
      bootFromOtp     <= policy[`OSC_PB_SECBOOT];
      redundantRowsOn <= policy[`OSC_PB_REDUND];
      swSecField      <= policy[`OSC_PB_SW_HI:`OSC_PB_SW_LO];
      if (portRead && running) begin
        otpRdData <= (addrReg <= `OSC_POLICY_ADDR) ? mem[addrReg[11:0]] : 32'h0;
      end
      otpStatus[`OSC_ST_BOOTING] <= !running;
      otpStatus[`OSC_ST_LOADED]  <= (bootState != BOOT_LOAD);
      if (progNo || (hitCtrl && !running)) begin
        otpStatus[`OSC_ST_REFUSED] <= 1'b1;
      end else if (progDo) begin
        otpStatus[`OSC_ST_REFUSED] <= 1'b0;
      end
    end
  end

endmodule : osc_otp_security

/* hw/osc_params.svh */
// Constants for the OTP security configuration block.
// Assumes inclusion by the top module, the assertion module and the bench top only.
`ifndef OSC_PARAMS_SVH
`define OSC_PARAMS_SVH

// ----------------------------------------
// Array geometry
// ----------------------------------------
`define OSC_ROWS        512
`define OSC_WORDS       2048
`define OSC_POLICY_ADDR 16'h0800

// ----------------------------------------
// Port resource numbers
// ----------------------------------------
`define OSC_RES_ADDR    24'h100200
`define OSC_RES_DATA    24'h200100
`define OSC_RES_CTRL    24'h100300

// ----------------------------------------
// Policy bit positions
// ----------------------------------------
`define OSC_PB_NOJTAG   0
`define OSC_PB_NOLINK   1
`define OSC_PB_SECBOOT  5
`define OSC_PB_REDUND   7
`define OSC_PB_SLOCK    8
`define OSC_PB_MLOCK    12
`define OSC_PB_NOJOTP   13
`define OSC_PB_SW_LO    15
`define OSC_PB_SW_HI    21
`define OSC_PB_UID_LO   22

// ----------------------------------------
// Control commands and status bits
// ----------------------------------------
`define OSC_CMD_PROG    2'h1
`define OSC_CMD_READ    2'h2
`define OSC_ST_REFUSED  0
`define OSC_ST_BOOTING  1
`define OSC_ST_LOADED   2

// ----------------------------------------
// Chip TAP instructions
// ----------------------------------------
`define OSC_IR_DEBUG_CHIP_IDENT   4'h1
`define OSC_IR_USERCODE 4'h2
`define OSC_IR_OTPADDR  4'h8
`define OSC_IR_OTPDATA  4'h9
`define OSC_IR_BYPASS   4'hf
`define OSC_IR_CAPTURE  4'h1

`endif

/* hw/osc_pkg.sv */
// Types for the OTP security configuration block.
// Assumes the params header sits beside it.
package osc_pkg;

  // ----------------------------------------
  // TAP controller states
  // ----------------------------------------
  typedef enum logic [3:0] {
    TAP_RESET, TAP_IDLE, TAP_SEL_DR, TAP_CAP_DR, TAP_SH_DR, TAP_EX1_DR,
    TAP_PAU_DR, TAP_EX2_DR, TAP_UPD_DR, TAP_SEL_IR, TAP_CAP_IR, TAP_SH_IR,
    TAP_EX1_IR, TAP_PAU_IR, TAP_EX2_IR, TAP_UPD_IR
  } osc_tap_t;

  typedef enum logic [1:0] {BOOT_LOAD, BOOT_COPY, BOOT_RUN} osc_boot_t;

  // ----------------------------------------
  // Carriers
  // ----------------------------------------
  typedef struct packed {
    logic        capDr;
    logic        shDr;
    logic        updDr;
    logic        shIr;
  } osc_tapev_t;

  typedef struct packed {
    logic        wr;
    logic [23:0] res;
    logic [31:0] data;
  } osc_req_t;

  typedef struct packed {
    logic        wr;
    logic [10:0] addr;
    logic [31:0] data;
  } osc_sram_t;

endpackage : osc_pkg

/* hw/osc_tap.sv */
// One TAP controller: state walk and instruction register.
// Assumes tckRise is a one-cycle pulse with tms and tdi already clean.
`timescale 1ns/10ps
module osc_tap
  import osc_pkg::*;
(
  // Clock and reset
  input  wire logic       clk,
  input  wire logic       rst_b,
  // Sampled test pins
  input  wire logic       tckRise,
  input  wire logic       tms,
  input  wire logic       tdi,
  // Data register serial output from the owner
  input  wire logic       drOut,
  // State towards the owner
  output logic [3:0]      ir,
  output osc_tapev_t      ev,
  output logic            serOut
);
  osc_tap_t   state;
  osc_tap_t   next_state;
  logic [3:0] irSh;

  // ----------------------------------------
  // State walk
  // ----------------------------------------
  // Five TMS-high clocks reach reset from any state
  always_comb begin
    unique case (state)
      TAP_RESET:  next_state = tms ? TAP_RESET  : TAP_IDLE;
      TAP_IDLE:   next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_DR: next_state = tms ? TAP_SEL_IR : TAP_CAP_DR;
      TAP_CAP_DR: next_state = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_SH_DR:  next_state = tms ? TAP_EX1_DR : TAP_SH_DR;
      TAP_EX1_DR: next_state = tms ? TAP_UPD_DR : TAP_PAU_DR;
      TAP_PAU_DR: next_state = tms ? TAP_EX2_DR : TAP_PAU_DR;
      TAP_EX2_DR: next_state = tms ? TAP_UPD_DR : TAP_SH_DR;
      TAP_UPD_DR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
      TAP_SEL_IR: next_state = tms ? TAP_RESET  : TAP_CAP_IR;
      TAP_CAP_IR: next_state = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_SH_IR:  next_state = tms ? TAP_EX1_IR : TAP_SH_IR;
      TAP_EX1_IR: next_state = tms ? TAP_UPD_IR : TAP_PAU_IR;
      TAP_PAU_IR: next_state = tms ? TAP_EX2_IR : TAP_PAU_IR;
      TAP_EX2_IR: next_state = tms ? TAP_UPD_IR : TAP_SH_IR;
      TAP_UPD_IR: next_state = tms ? TAP_SEL_DR : TAP_IDLE;
    endcase
  end

  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      state <= TAP_RESET;
    end else if (tckRise) begin
      state <= next_state;
    end
  end

  // ----------------------------------------
  // Instruction register
  // ----------------------------------------
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      ir   <= `OSC_IR_DEBUG_CHIP_IDENT;
      irSh <= 4'h0;
    end else if (tckRise) begin
      if (state == TAP_RESET) begin
        ir <= `OSC_IR_DEBUG_CHIP_IDENT;
      end else if (state == TAP_CAP_IR) begin
        irSh <= `OSC_IR_CAPTURE;
      end else if (state == TAP_SH_IR) begin
        irSh <= {tdi, irSh[3:1]};
      end else if (state == TAP_UPD_IR) begin
        ir <= irSh;
      end
    end
  end

  assign ev.capDr = (state == TAP_CAP_DR);
  assign ev.shDr  = (state == TAP_SH_DR);
  assign ev.updDr = (state == TAP_UPD_DR);
  assign ev.shIr  = (state == TAP_SH_IR);
  assign serOut   = ev.shIr ? irSh[0] : drOut;

endmodule : osc_tap

/* bench/osc_otp_security_assertions.sv */
// Port checks for the OTP security block.
// Assumes binding to osc_otp_security with its port names.
`timescale 1ns/10ps
`include "osc_params.svh"
module osc_sec_assert
  import osc_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        rst_b,
  // Port bus and boot
  input wire osc_req_t    portReq,
  input wire logic [31:0] otpRdData,
  input wire logic [15:0] otpStatus,
  input wire osc_sram_t   sramWr,
  input wire logic        bootDone,
  // Policy effects
  input wire logic        bootFromOtp,
  input wire logic        linkReq,
  input wire logic        linkGrant,
  input wire logic        linkRefused,
  input wire logic        redundantRowsOn,
  input wire logic [6:0]  swSecField
);
  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  wire ctlWr = portReq.wr && portReq.res == `OSC_RES_CTRL;

  a_link_answer: assert property (linkReq |=> linkGrant ^ linkRefused)
    else $error("link request answered wrongly");
  a_link_idle: assert property (!linkReq |=> !linkGrant && !linkRefused)
    else $error("link answer without request");
  a_grant_after_boot: assert property (linkGrant |-> bootDone)
    else $error("link granted before boot");
  a_copy_in_order: assert property (sramWr.wr && sramWr.addr != 11'h7ff |=>
    sramWr.wr && sramWr.addr == $past(sramWr.addr) + 11'h1)
    else $error("boot copy not sequential");
  a_copy_before_done: assert property (sramWr.wr |-> !bootDone)
    else $error("copy after boot done");
  a_done_holds: assert property (bootDone |=> bootDone)
    else $error("boot done dropped");
  a_policy_steady: assert property (bootDone |=> $stable(bootFromOtp)
    && $stable(redundantRowsOn) && $stable(swSecField))
    else $error("policy output moved after boot");
  a_early_ctl_refused: assert property (ctlWr && !bootDone |-> ##[1:3] otpStatus[0])
    else $error("early command not refused");
  a_read_on_cmd: assert property ($changed(otpRdData) |-> $past(ctlWr) || $past(ctlWr, 2))
    else $error("read data moved without command");
  a_status_spare: assert property (otpStatus[15:3] == 13'h0)
    else $error("spare status bits set");

  c_boot: cover property ($rose(bootDone));
  c_refuse_link: cover property (linkReq ##1 linkRefused);
  c_refuse_prog: cover property (ctlWr && bootDone ##2 otpStatus[0]);
endmodule : osc_sec_assert

bind osc_otp_security osc_sec_assert u_chk (.clk(clk), .rst_b(rst_b), .portReq(portReq),
  .otpRdData(otpRdData), .otpStatus(otpStatus), .sramWr(sramWr), .bootDone(bootDone),
  .bootFromOtp(bootFromOtp), .linkReq(linkReq), .linkGrant(linkGrant),
  .linkRefused(linkRefused), .redundantRowsOn(redundantRowsOn), .swSecField(swSecField));

/* bench/osc_jtag_host.sv */
// Debug host model on the test pins, paced by the tile clock.
// Assumes tdo arrives resolved from the pin and its enable.
`timescale 1ns/10ps
module osc_jtag_host (
  // Pacing clock
  input wire logic clk,
  // Test pins
  output logic     tck,
  output logic     tms,
  output logic     tdi,
  input wire logic tdo
);
  // Test clock stands low between frames
  initial begin
    tck = 1'b0;
    tms = 1'b1;
    tdi = 1'b0;
  end

  // Eight clocks a half period keeps the pin synchroniser clear
  task automatic pulse(input logic m, input logic d, output logic q);
    tms <= m;
    tdi <= d;
    repeat (8) @(posedge clk);
    q = tdo;
    tck <= 1'b1;
    repeat (8) @(posedge clk);
    tck <= 1'b0;
  endtask : pulse

  task automatic tapReset();
    logic q;
    repeat (5) pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask : tapReset

  // Same code in both controllers, so the chain order cannot matter
  task automatic scanIr(input logic [3:0] code);
    logic q;
    pulse(1'b1, 1'b0, q);
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    for (int i = 0; i < 8; i++) pulse(i == 7, code[i % 4], q);
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask : scanIr

  task automatic scanDr(output logic [32:0] v);
    logic q;
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    pulse(1'b0, 1'b0, q);
    for (int i = 0; i < 33; i++) begin
      pulse(i == 32, 1'b0, q);
      v[i] = q;
    end
    pulse(1'b1, 1'b0, q);
    pulse(1'b0, 1'b0, q);
  endtask : scanDr
endmodule : osc_jtag_host

/* bench/osc_otp_security_tb_top.sv */
// Bench for the OTP security block: programming, boot, policy, debug reads.
// Assumes a blank OTP at time zero and the debug host model on the pins.
`timescale 1ns/10ps
`include "osc_params.svh"
module osc_otp_security_tb_top
  import osc_pkg::*;
;
  // Identification values are arbitrary
  localparam logic [3:0]  IdVer = 4'h3;
  localparam logic [15:0] IdPrt = 16'h0123;
  localparam logic [10:0] IdMkr = 11'h05a;
  localparam logic [17:0] Rev   = 18'h00a5c;
  localparam logic [31:0] Pol   = {10'h2a5, 7'h55, 6'h0, 3'b110, 1'b1, 3'h0, 2'b10};

  logic        clk, rst_b, linkReq, bootDone, bootFromOtp, linkGrant, linkRefused;
  logic        redundantRowsOn, tck, tms, tdi, tdo, tdoEn_b, tdoLine;
  logic [31:0] otpRdData;
  logic [15:0] otpStatus;
  logic [6:0]  swSecField;
  osc_req_t    portReq;
  osc_sram_t   sramWr;
  int          errors, checksDone, copyCount;

  initial clk = 1'b0;
  always #50 clk = ~clk;
  always @(negedge clk) if (sramWr.wr === 1'b1) copyCount++;
  // A released pin shows the inverse, never a stale value
  assign tdoLine = tdoEn_b ? ~tdo : tdo;

  osc_otp_security #(.IdVersion(IdVer), .IdPart(IdPrt), .IdMaker(IdMkr), .SiliconRev(Rev))
    dut (.clk(clk), .rst_b(rst_b), .portReq(portReq), .otpRdData(otpRdData),
    .otpStatus(otpStatus), .sramWr(sramWr), .bootDone(bootDone), .bootFromOtp(bootFromOtp),
    .linkReq(linkReq), .linkGrant(linkGrant), .linkRefused(linkRefused),
    .redundantRowsOn(redundantRowsOn), .swSecField(swSecField), .tck(tck), .tms(tms),
    .tdi(tdi), .tdo(tdo), .tdoEn_b(tdoEn_b));
  osc_jtag_host host (.clk(clk), .tck(tck), .tms(tms), .tdi(tdi), .tdo(tdoLine));

  // ----------------------------------------
  // Shared tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    checksDone++;
    if (seen !== exp) begin
      errors++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk

  task automatic final_report();
    $display("checks=%0d errors=%0d", checksDone, errors);
    if (errors == 0 && checksDone > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask : final_report

  task automatic portWr(input logic [23:0] res, input logic [31:0] d);
    @(posedge clk);
    portReq <= '{wr: 1'b1, res: res, data: d};
    @(posedge clk);
    portReq.wr <= 1'b0;
  endtask : portWr

  task automatic progW(input logic [15:0] a, input logic [31:0] d);
    portWr(`OSC_RES_ADDR, {16'h0, a});
    portWr(`OSC_RES_DATA, d);
    portWr(`OSC_RES_CTRL, {30'h0, `OSC_CMD_PROG});
    repeat (3) @(posedge clk);
  endtask : progW

  task automatic readW(input logic [15:0] a, output logic [31:0] d);
    portWr(`OSC_RES_ADDR, {16'h0, a});
    portWr(24'h100400, 32'h0000_0007);
    portWr(`OSC_RES_CTRL, {30'h0, `OSC_CMD_READ});
    repeat (3) @(posedge clk);
    d = otpRdData;
  endtask : readW

  // Reset, then a command during the copy, which must be refused
  task automatic doReset();
    int n;
    @(posedge clk);
    rst_b <= 1'b0;
    repeat (3) @(posedge clk);
    copyCount = 0;
    rst_b <= 1'b1;
    portWr(`OSC_RES_CTRL, {30'h0, `OSC_CMD_READ});
    repeat (2) @(posedge clk);
    @(negedge clk);
    chk({31'h0, otpStatus[0]}, 32'h1);
    n = 0;
    while (bootDone !== 1'b1 && n < 3000) begin
      @(posedge clk);
      n++;
    end
    if (n == 3000) begin
      errors++;
      final_report();
    end
    chk(copyCount, 32'd2048);
  endtask : doReset

  task automatic linkTry(input logic grant);
    @(posedge clk);
    linkReq <= 1'b1;
    @(posedge clk);
    @(negedge clk);
    chk({linkGrant, linkRefused}, {grant, ~grant});
    @(posedge clk);
    linkReq <= 1'b0;
  endtask : linkTry

  task automatic jtagRead(input logic [3:0] code, input logic [31:0] exp);
    logic [32:0] v;
    host.tapReset();
    host.scanIr(code);
    host.scanDr(v);
    // Chip word leaves first; the boundary bypass bit trails it
    chk(v[31:0], exp);
    chk({31'h0, v[32]}, 32'h0);
  endtask : jtagRead

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    logic [31:0] d;
    rst_b = 1'b0;
    linkReq = 1'b0;
    portReq = '0;
    doReset();
    chk({bootFromOtp, redundantRowsOn, swSecField}, 32'h0);
    linkTry(1'b1);
    jtagRead(`OSC_IR_DEBUG_CHIP_IDENT, {IdVer, IdPrt, IdMkr, 1'b1});
    jtagRead(`OSC_IR_USERCODE, {10'h0, 4'h0, Rev});
    progW(16'h0005, 32'h0000_00a5);
    progW(16'h0005, 32'h0000_5a00);
    chk({31'h0, otpStatus[0]}, 32'h0);
    readW(16'h0005, d);
    chk(d, 32'h0000_5aa5);
    progW(16'h0801, 32'h0000_0001);
    chk({31'h0, otpStatus[0]}, 32'h1);
    progW(`OSC_POLICY_ADDR, Pol);
    doReset();
    chk({bootFromOtp, redundantRowsOn, swSecField}, {2'b11, 7'h55});
    linkTry(1'b0);
    jtagRead(`OSC_IR_USERCODE, {10'h2a5, 4'h0, Rev});
    progW(16'h0003, 32'hffff_ffff);
    chk({31'h0, otpStatus[0]}, 32'h1);
    readW(16'h0003, d);
    chk(d, 32'h0);
    progW(16'h0200, 32'h0000_0033);
    readW(16'h0200, d);
    chk(d, 32'h0000_0033);
    progW(`OSC_POLICY_ADDR, 32'h0000_3001);
    doReset();
    progW(16'h0201, 32'h0000_0001);
    chk({31'h0, otpStatus[0]}, 32'h1);
    readW(16'h0201, d);
    chk(d, 32'h0);
    progW(`OSC_POLICY_ADDR, 32'h0000_0040);
    readW(`OSC_POLICY_ADDR, d);
    chk(d, Pol | 32'h0000_3001);
    jtagRead(`OSC_IR_DEBUG_CHIP_IDENT, 32'h0);
    final_report();
  end
endmodule : osc_otp_security_tb_top
